// ===== api_frame_defs.vh
`ifndef API_FRAME_DEFS_VH
`define API_FRAME_DEFS_VH
// frame delimiters and escape codes
`define START_DELIM     8'h7E
`define ESC_BYTE        8'h7D
`define XON_BYTE        8'h11
`define XOFF_BYTE       8'h13
`define ESC_XOR         8'h20
`define CSUM_BASE       8'hFF
// frame types
`define TYPE_TX_REQ     8'h10
`define TYPE_TX_EXPL    8'h11
`define TYPE_TX_STATUS  8'h8B
// field offsets within the frame
`define OFS_LEN_MSB     16'h0001
`define OFS_LEN_LSB     16'h0002
`define OFS_TYPE        16'h0003
`define OFS_ID          16'h0004
`define OFS_DST64_FIRST 16'h0005
`define OFS_DST64_LAST  16'h000C
`define OFS_NET_MSB     16'h000D
`define OFS_NET_LSB     16'h000E
`define OFS_RADIUS_STD  16'h000F
`define OFS_OPT_STD     16'h0010
`define OFS_RADIUS_EXPL 16'h0015
`define OFS_OPT_EXPL    16'h0016
// special addresses
`define BCAST_ADDR64    64'h0000_0000_0000_FFFF
`define NET_UNKNOWN     16'hFFFE
`define NET_COORD       16'h0000
`define RADIUS_USE_MAX  8'h00
// api mode codes
`define MODE_ESCAPED    2'h2
`define MODE_VERBATIM   2'h1
`endif

// ===== api_transmit_frame_codec.v
`timescale 1ns/1ps
`default_nettype none
`include "api_frame_defs.vh"

// Summary of operation
// - in escaped mode, 0x13 travels as 0x7D 0x33 and is restored on receipt
// - verbatim mode passes every byte unchanged, no escapes added or removed
// - checksum is 0xFF minus low byte of sum, frame type through payload
// - length counts frame type through payload, not delimiter, length or checksum
// - 64-bit destination at offsets 5-12, network address at 13-14, msb first
// - type 0x11 decodes as explicit transmit with same addressing as 0x10
// - frame id zero suppresses response; nonzero id is echoed in status
// - destination 0x000000000000FFFF means broadcast
// - coordinator is zero address with 0xFFFE, or coordinator address with 0x0000
// - network 0xFFFE is unknown; status frame 0x8B reports discovered address
// - radius used only for broadcast; zero radius takes the max hop setting
module api_transmit_frame_codec (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire [1:0]  api_escape_mode_select,
  input  wire [7:0]  max_hop_count_setting,
  input  wire [63:0] coord_addr64,
  input  wire        rx_valid,
  input  wire [7:0]  rx_byte,
  output reg         req_valid,
  output reg         req_explicit,
  output reg         req_broadcast,
  output reg         req_coord,
  output reg         req_net_unknown,
  output reg  [7:0]  req_frame_id,
  output reg  [63:0] req_addr64,
  output reg  [15:0] req_addr16,
  output reg  [7:0]  req_radius,
  output reg  [7:0]  req_options,
  output reg         frame_error,
  output reg         pay_valid,
  output reg  [7:0]  pay_byte,
  input  wire        st_valid,
  input  wire [7:0]  st_frame_id,
  input  wire [15:0] st_addr16,
  input  wire [7:0]  st_retries,
  input  wire [7:0]  st_delivery,
  input  wire [7:0]  st_discovery,
  output reg         st_busy,
  input  wire        tx_ready,
  output reg         tx_valid,
  output reg  [7:0]  tx_byte
);

  // one-hot states, shared by the deframer and the status framer
  localparam S_IDLE = 3'b001;
  localparam S_BODY = 3'b010;
  localparam S_CSUM = 3'b100;

  // escape test used by the status framer only
  function need_esc;
    input [7:0] b;
    begin
      need_esc = (b == `START_DELIM) || (b == `ESC_BYTE) || (b == `XON_BYTE) || (b == `XOFF_BYTE);
    end
  endfunction

  // status frame byte n (0 = delimiter)
  function [7:0] st_frame_byte;
    input [3:0]  n;
    input [7:0]  id;
    input [15:0] a16;
    input [7:0]  rt;
    input [7:0]  dl;
    input [7:0]  ds;
    input [7:0]  cs;
    begin
      case (n)
        4'h0: st_frame_byte = `START_DELIM;
        4'h1: st_frame_byte = 8'h00;
        4'h2: st_frame_byte = 8'h07;
        4'h3: st_frame_byte = `TYPE_TX_STATUS;
        4'h4: st_frame_byte = id;
        4'h5: st_frame_byte = a16[15:8];
        4'h6: st_frame_byte = a16[7:0];
        4'h7: st_frame_byte = rt;
        4'h8: st_frame_byte = dl;
        4'h9: st_frame_byte = ds;
        default: st_frame_byte = cs;
      endcase
    end
  endfunction

  // mode input crosses from configuration logic, treated as asynchronous
  reg [1:0] mode_s1_r, mode_r;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_s1_r <= 2'h0;
      mode_r    <= 2'h0;
    end else begin
      mode_s1_r <= api_escape_mode_select;
      mode_r    <= mode_s1_r;
    end
  end
  wire escaping = (mode_r == `MODE_ESCAPED);

  // deframer
  reg [2:0]  rx_state_r;
  reg        esc_pend_r;
  reg [15:0] ofs_r;
  reg [15:0] len_r;
  reg [7:0]  sum_r;
  reg        expl_r;
  reg [7:0]  type_r;

  // escape removal only in escaped mode; verbatim passes 0x7D through
  wire       is_esc   = escaping && rx_valid && (rx_byte == `ESC_BYTE) && !esc_pend_r;
  wire [7:0] ub       = esc_pend_r ? (rx_byte ^ `ESC_XOR) : rx_byte;
  wire       ub_valid = rx_valid && !is_esc;
  // verbatim mode carries no escapes, so a 0x7e inside a frame is data
  wire       restart  = rx_valid && (rx_byte == `START_DELIM) && !esc_pend_r &&
                        (escaping || (rx_state_r == S_IDLE));
  wire [15:0] body_end = len_r + 16'h0002;     // last payload offset
  wire [15:0] opt_ofs  = expl_r ? `OFS_OPT_EXPL : `OFS_OPT_STD;
  wire [15:0] rad_ofs  = expl_r ? `OFS_RADIUS_EXPL : `OFS_RADIUS_STD;
  // shortest legal body still reaches the options byte; payload may be empty
  wire [15:0] min_len  = opt_ofs - 16'h0002;

  // destination class, decoded from the captured address fields
  wire        addr_bcast = (req_addr64 == `BCAST_ADDR64);
  wire        addr_zero  = (req_addr64 == 64'h0000_0000_0000_0000);
  wire        addr_own   = (req_addr64 == coord_addr64);
  // coordinator by reserved zero address or by its own address
  wire        coord_hit  = (addr_zero && (req_addr16 == `NET_UNKNOWN)) ||
                           (addr_own && (req_addr16 == `NET_COORD));
  // radius matters only for broadcast; zero picks the hop setting
  wire [7:0]  radius_eff = !addr_bcast ? 8'h00 :
                           (req_radius == `RADIUS_USE_MAX) ? max_hop_count_setting : req_radius;
  // a frame is taken only when checksum, type and length all agree
  wire        csum_ok    = ((`CSUM_BASE - sum_r) == ub);
  wire        type_ok    = (type_r == `TYPE_TX_REQ) || (type_r == `TYPE_TX_EXPL);
  wire        len_ok     = (len_r >= min_len);

  // byte-by-byte field capture; an unescaped delimiter restarts in escaped mode, or in S_IDLE in verbatim mode
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_r <= S_IDLE;
      esc_pend_r <= 1'b0;
      ofs_r <= 16'h0000;
      len_r <= 16'h0000;
      sum_r <= 8'h00;
      expl_r <= 1'b0;
      type_r <= 8'h00;
      req_valid <= 1'b0;
      req_explicit <= 1'b0;
      req_broadcast <= 1'b0;
      req_coord <= 1'b0;
      req_net_unknown <= 1'b0;
      req_frame_id <= 8'h00;
      req_addr64 <= 64'h0000_0000_0000_0000;
      req_addr16 <= 16'h0000;
      req_radius <= 8'h00;
      req_options <= 8'h00;
      frame_error <= 1'b0;
      pay_valid <= 1'b0;
      pay_byte <= 8'h00;
    end else begin
      req_valid   <= 1'b0;
      frame_error <= 1'b0;
      pay_valid   <= 1'b0;
      if (rx_valid)
        esc_pend_r <= is_esc;
      if (restart) begin
        rx_state_r <= S_BODY;
        ofs_r <= `OFS_LEN_MSB;
        sum_r <= 8'h00;
      end else if (ub_valid) begin
        case (rx_state_r)
          S_BODY: begin
            ofs_r <= ofs_r + 16'h0001;
            // delimiter and length bytes stay out of the sum
            if (ofs_r >= `OFS_TYPE)
              sum_r <= sum_r + ub;
            if (ofs_r == `OFS_LEN_MSB)
              len_r[15:8] <= ub;
            if (ofs_r == `OFS_LEN_LSB)
              len_r[7:0] <= ub;
            if (ofs_r == `OFS_TYPE) begin
              type_r <= ub;
              expl_r <= (ub == `TYPE_TX_EXPL);
            end
            if (ofs_r == `OFS_ID)
              req_frame_id <= ub;
            if (ofs_r >= `OFS_DST64_FIRST && ofs_r <= `OFS_DST64_LAST)
              req_addr64 <= {req_addr64[55:0], ub};
            if (ofs_r == `OFS_NET_MSB)
              req_addr16[15:8] <= ub;
            if (ofs_r == `OFS_NET_LSB)
              req_addr16[7:0] <= ub;
            if (ofs_r == rad_ofs)
              req_radius <= ub;
            if (ofs_r == opt_ofs)
              req_options <= ub;
            if (ofs_r > opt_ofs) begin
              pay_valid <= 1'b1;
              pay_byte  <= ub;
            end
            // length is whole only once the type byte arrives
            if (ofs_r >= `OFS_TYPE && ofs_r == body_end)
              rx_state_r <= S_CSUM;
          end
          S_CSUM: begin
            rx_state_r <= S_IDLE;
            if (csum_ok && type_ok && len_ok) begin
              req_valid       <= 1'b1;
              req_explicit    <= expl_r;
              req_broadcast   <= addr_bcast;
              req_coord       <= coord_hit;
              req_net_unknown <= (req_addr16 == `NET_UNKNOWN);
              req_radius      <= radius_eff;
            end else begin
              // bad checksum, unknown type or short body
              frame_error <= 1'b1;
            end
          end
          default: rx_state_r <= S_IDLE;
        endcase
      end
    end
  end

  // status framer
  reg [2:0] tx_state_r;
  reg [3:0] tx_idx_r;
  reg       tx_esc_r;
  // status fields captured at the request, held while the frame drains
  reg [7:0] st_id_r, st_rt_r, st_dl_r, st_ds_r, tx_sum_r;
  reg [15:0] st_a16_r;
  wire [7:0] cur = st_frame_byte(tx_idx_r, st_id_r, st_a16_r, st_rt_r, st_dl_r, st_ds_r, `CSUM_BASE - tx_sum_r);
  wire       esc_here = escaping && (tx_idx_r != 4'h0) && need_esc(cur);

  // status frames only for nonzero ids; escape bytes inserted on the fly
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_r <= S_IDLE;
      tx_idx_r <= 4'h0;
      tx_esc_r <= 1'b0;
      st_id_r <= 8'h00;
      st_a16_r <= 16'h0000;
      st_rt_r <= 8'h00;
      st_dl_r <= 8'h00;
      st_ds_r <= 8'h00;
      tx_sum_r <= 8'h00;
      st_busy <= 1'b0;
      tx_valid <= 1'b0;
      tx_byte <= 8'h00;
    end else begin
      case (tx_state_r)
        S_IDLE: begin
          if (st_valid && st_frame_id != 8'h00) begin
            st_id_r  <= st_frame_id;
            st_a16_r <= st_addr16;
            st_rt_r  <= st_retries;
            st_dl_r  <= st_delivery;
            st_ds_r  <= st_discovery;
            tx_idx_r <= 4'h0;
            tx_sum_r <= 8'h00;
            tx_esc_r <= 1'b0;
            st_busy  <= 1'b1;
            tx_state_r <= S_BODY;
          end
        end
        S_BODY: begin
          // a byte stands until the host takes it
          if (!tx_valid || tx_ready) begin
            tx_valid <= 1'b1;
            // escape byte first, the masked byte on the next grant
            if (esc_here && !tx_esc_r) begin
              tx_byte  <= `ESC_BYTE;
              tx_esc_r <= 1'b1;
            end else begin
              tx_byte  <= esc_here ? (cur ^ `ESC_XOR) : cur;
              tx_esc_r <= 1'b0;
              if (tx_idx_r >= 4'h3)
                tx_sum_r <= tx_sum_r + cur;
              tx_idx_r <= tx_idx_r + 4'h1;
              if (tx_idx_r == 4'hA)
                tx_state_r <= S_CSUM;
            end
          end
        end
        S_CSUM: begin
          if (tx_ready) begin
            tx_valid <= 1'b0;
            st_busy  <= 1'b0;
            tx_state_r <= S_IDLE;
          end
        end
        default: tx_state_r <= S_IDLE;
      endcase
    end
  end

endmodule // api_transmit_frame_codec
`default_nettype wire

// ===== api_codec_chk.sv
`timescale 1ns/1ps
`default_nettype none
module api_codec_chk (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic [1:0]  api_escape_mode_select,
  input wire logic [63:0] coord_addr64,
  input wire logic        req_valid,
  input wire logic        req_broadcast,
  input wire logic        req_coord,
  input wire logic        req_net_unknown,
  input wire logic [63:0] req_addr64,
  input wire logic [15:0] req_addr16,
  input wire logic [7:0]  req_radius,
  input wire logic        st_valid,
  input wire logic [7:0]  st_frame_id,
  input wire logic        st_busy,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic [7:0]  tx_byte
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // status request taken only when idle and numbered, delimiter follows
  sequence st_take; st_valid && !st_busy && st_frame_id != 8'h00; endsequence
  sequence st_open; st_busy ##1 tx_valid && tx_byte == 8'h7E; endsequence
  bcast_flag_a: assert property (req_valid |-> req_broadcast == (req_addr64 == 64'h0000_0000_0000_FFFF))
    else $error("bad broadcast flag");
  net_unknown_a: assert property (req_valid |-> req_net_unknown == (req_addr16 == 16'hFFFE))
    else $error("bad unknown flag");
  coord_sel_a: assert property (req_valid |-> req_coord == (req_addr64 == 64'h0 && req_addr16 == 16'hFFFE ||
    req_addr64 == coord_addr64 && req_addr16 == 16'h0000)) else $error("bad coord flag");
  radius_zero_a: assert property (req_valid && !req_broadcast |-> req_radius == 8'h00)
    else $error("radius kept");
  id_zero_a: assert property (st_valid && !st_busy && st_frame_id == 8'h00 |=> !st_busy)
    else $error("status for id zero");
  status_open_a: assert property (st_take |=> st_open)
    else $error("status not started");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("status byte dropped");
  no_raw_ctl_a: assert property (api_escape_mode_select == 2'h2 && tx_valid |->
    !(tx_byte inside {8'h11, 8'h13})) else $error("control byte raw");
endmodule // api_codec_chk
bind api_transmit_frame_codec api_codec_chk i_api_codec_chk (.*);
`default_nettype wire

// ===== api_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module api_host_model (
  input  wire logic       mclk,
  input  wire logic       esc,
  input  wire logic       slow,
  output var logic        rx_valid,
  output var logic [7:0]  rx_byte,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte,
  output var logic        tx_ready,
  output var logic        got_valid,
  output var logic [7:0]  got_byte
);
  logic       was_esc;
  logic [3:0] cnt;
  initial begin
    {rx_valid, rx_byte, tx_ready, got_valid, got_byte, was_esc, cnt} = '0;
  end
  // released data shows the inverse so a stale byte never passes
  task automatic put(input logic [7:0] b, input logic raw);
    @(posedge mclk);
    #1;
    if (esc && !raw && b inside {8'h7E, 8'h7D, 8'h11, 8'h13}) begin
      {rx_valid, rx_byte} = {1'b1, 8'h7D};
      @(posedge mclk);
      #1;
      b = b ^ 8'h20;
    end
    {rx_valid, rx_byte} = {1'b1, b};
    @(posedge mclk);
    #1;
    {rx_valid, rx_byte} = {1'b0, ~b};
  endtask
  task automatic send_frame(input logic [7:0] typ, id, input logic [63:0] a64, input logic [15:0] a16,
                            input logic [7:0] rad, opt, pb, input int n, input logic bad);
    logic [7:0] q[$];
    logic [7:0] sum;
    q = {typ, id};
    for (int k = 7; k >= 0; k--) q.push_back(a64[8*k +: 8]);
    q = {q, a16[15:8], a16[7:0]};
    if (typ == 8'h11) q = {q, 8'hA0, 8'hA1, 8'h15, 8'h54, 8'hC1, 8'h05};
    q = {q, rad, opt};
    for (int k = 0; k < n; k++) q.push_back(pb + 8'(k));
    sum = 8'h00;
    foreach (q[j]) sum += q[j];
    put(8'h7E, 1'b1);
    put(8'h00, 1'b0);
    put(8'(q.size()), 1'b0);
    foreach (q[j]) put(q[j], 1'b0);
    put(8'hFF - sum ^ {7'h0, bad}, 1'b0);
  endtask
  // slow mode grants one cycle in four
  always @(posedge mclk) begin
    cnt <= cnt + 4'h1;
    tx_ready <= !slow || cnt[1:0] == 2'h0;
    got_valid <= 1'b0;
    if (tx_valid && tx_ready) begin
      was_esc <= esc && !was_esc && tx_byte == 8'h7D;
      got_valid <= !(esc && !was_esc && tx_byte == 8'h7D);
      got_byte <= was_esc ? tx_byte ^ 8'h20 : tx_byte;
    end
  end
endmodule // api_host_model
`default_nettype wire

// ===== test_api_transmit_frame_codec.sv
`timescale 1ns/1ps
`default_nettype none
module test_api_transmit_frame_codec;
  logic         mclk, rst_n, rx_valid, req_valid, req_explicit, req_broadcast, req_coord, req_net_unknown;
  logic         frame_error, pay_valid, st_valid, st_busy, tx_ready, tx_valid, esc, slow, got_valid;
  logic [1:0]   api_escape_mode_select;
  logic [7:0]   max_hop_count_setting, rx_byte, req_frame_id, req_radius, req_options, pay_byte, tx_byte, got_byte;
  logic [7:0]   st_frame_id, st_retries, st_delivery, st_discovery, payq[$], stq[$];
  logic [15:0]  req_addr16, st_addr16;
  logic [63:0]  coord_addr64, req_addr64;
  logic [108:0] reqq[$];
  integer       num_errors, cmp_count, seed, i;
  api_transmit_frame_codec i_api_transmit_frame_codec (.*);
  api_host_model i_api_host_model (.*);
  task chk(input string nm, input logic [108:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task final_report;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task frame(input logic [7:0] typ, id, input logic [63:0] a64, input logic [15:0] a16,
             input logic [7:0] rad, opt, pb, input int n, input logic bad);
    logic bc;
    bc = a64 == 64'h0000_0000_0000_FFFF;
    if (bad || !(typ inside {8'h10, 8'h11})) reqq.push_back({1'b1, 108'h0});
    else reqq.push_back({1'b0, typ == 8'h11, bc,
      a64 == 64'h0 && a16 == 16'hFFFE || a64 == coord_addr64 && a16 == 16'h0000,
      a16 == 16'hFFFE, id, a64, a16, bc ? (rad == 8'h00 ? max_hop_count_setting : rad) : 8'h00, opt});
    for (i = 0; i < n; i++) payq.push_back(pb + 8'(i));
    i_api_host_model.send_frame(typ, id, a64, a16, rad, opt, pb, n, bad);
  endtask
  task status(input logic [7:0] id);
    logic [7:0] sum;
    @(posedge mclk);
    #1;
    {st_valid, st_frame_id, st_addr16} = {1'b1, id, 16'($random(seed))};
    {st_retries, st_delivery, st_discovery} = {8'h7D, 8'h11, 8'h13}; // control values force escapes
    sum = 8'h8B + id + st_addr16[15:8] + st_addr16[7:0] + st_retries + st_delivery + st_discovery;
    if (id != 8'h00) stq = {stq, 8'h7E, 8'h00, 8'h07, 8'h8B, id, st_addr16[15:8], st_addr16[7:0]};
    if (id != 8'h00) stq = {stq, st_retries, st_delivery, st_discovery, 8'hFF - sum};
    @(posedge mclk);
    #1;
    st_valid = 1'b0;
  endtask
  task drain(input string nm);
    for (i = 0; i < 3000 && reqq.size() + payq.size() + stq.size() > 0; i++) @(posedge mclk);
    #1;
    if (i == 3000) begin
      chk("timeout", 1, 0);
      final_report;
    end else $display("test %s done", nm);
  endtask
  // oldest note matched as each result appears; error frames compare the flag only
  always @(posedge mclk) begin
    if (req_valid || frame_error) chk("request", {frame_error, req_explicit, req_broadcast, req_coord, req_net_unknown,
      req_frame_id, req_addr64, req_addr16, req_radius, req_options} & (frame_error ? {1'b1, 108'h0} : '1),
      reqq.pop_front());
    if (pay_valid) chk("payload", pay_byte, payq.pop_front());
    if (got_valid) chk("status", got_byte, stq.pop_front());
  end
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    {num_errors, cmp_count, seed} = {32'd0, 32'd0, 32'h4e54};
    {rst_n, st_valid, esc, slow, st_frame_id, st_addr16, st_retries, st_delivery, st_discovery} = '0;
    {api_escape_mode_select, max_hop_count_setting, coord_addr64} = {2'h1, 8'h0A, 64'h0102_0304_0506_0708};
    repeat (8) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    frame(8'h10, 8'h01, 64'h0011_2233_7D13_4455, 16'hFFFE, 8'h03, 8'h00, 8'h76, 8, 0);
    frame(8'h10, 8'h00, 64'hFFFF, 16'hFFFE, 8'h00, 8'h01, 8'h30, 2, 0);
    frame(8'h11, 8'h05, 64'hFFFF, 16'hFFFE, 8'h05, 8'h40, 8'h41, 3, 0);
    frame(8'h10, 8'h02, 64'h0, 16'hFFFE, 8'h00, 8'h20, 8'h50, 1, 0);
    frame(8'h11, 8'h03, coord_addr64, 16'h0000, 8'h00, 8'h00, 8'h60, 0, 0);
    frame(8'h10, 8'h04, coord_addr64, 16'hFFFE, 8'h00, 8'h00, 8'h00, 0, 1);
    frame(8'h12, 8'h04, 64'h1, 16'h0001, 8'h00, 8'h00, 8'h00, 0, 0);
    drain("verbatim");
    {api_escape_mode_select, esc} = {2'h2, 1'b1};
    repeat (4) @(posedge mclk);
    frame(8'h10, 8'h13, 64'h7E7D_1113_0000_FFFE, 16'h7D13, 8'h11, 8'h00, 8'h78, 8, 0);
    for (int k = 0; k < 6; k++)
      frame(8'h10 + 8'({$random(seed)} % 2), 8'($random(seed)), {$random(seed), $random(seed)}, 16'($random(seed)),
        8'($random(seed)), 8'($random(seed)) & 8'h61, 8'($random(seed)), {$random(seed)} % 9, 0);
    drain("escaped");
    slow = 1'b1;
    status(8'h00);
    status(8'h13);
    drain("status slow");
    slow = 1'b0;
    status(8'h7E);
    drain("status fast");
    final_report;
  end
endmodule // test_api_transmit_frame_codec
`default_nettype wire
